// ---- shared/sscp_pkg.sv ----
// Shared constants and types for the switch serial control front end.
package sscp_pkg;
  // Core clock rate and derived scaling.
  localparam int CLK_MHZ = 200;
  localparam int CYC_PER_MS = CLK_MHZ * 1000;
  // Serial frame layout.
  localparam int FRAME_BITS = 8;
  localparam logic [3:0] FRAME_BITS_CNT = 4'h8;
  localparam logic [3:0] FRAME_CNT_SAT = 4'h9;
  localparam int CMD_WD_BIT = 7;
  localparam int CMD_SEL_MSB = 6;
  localparam int CMD_SEL_LSB = 4;
  localparam int CMD_DATA_MSB = 3;
  // Command register selects.
  localparam logic [2:0] REG_OUT_CTRL = 3'h0;
  localparam logic [2:0] REG_OC_CFG = 3'h1;
  localparam logic [2:0] REG_SENSE = 3'h2;
  localparam logic [2:0] REG_WD_CFG = 3'h3;
  // Field positions inside the command registers.
  localparam int OUT_SPI_ON_LSB = 0;
  localparam int OUT_DIRECT_EN_LSB = 2;
  localparam int SENSE_CHAN_BIT = 0;
  localparam int SENSE_EN_BIT = 1;
  // Values after reset.
  localparam logic [3:0] OUT_CTRL_RST = 4'h0;
  localparam logic [3:0] OC_CFG_RST = 4'h0;
  localparam logic [1:0] SENSE_RST = 2'h0;
  localparam logic [1:0] WD_CFG_RST = 2'h0;
  localparam logic [7:0] STATUS_RST = 8'h00;
  // Overcurrent blanking times and levels.
  localparam int OCH_US = 10;
  localparam int OCH_CYC = OCH_US * CLK_MHZ;
  localparam int OCL0_US = 155000;
  localparam int OCL1_US = 10000;
  localparam int OCL2_US = 1200;
  localparam int OCL3_US = 150;
  localparam logic [7:0] OVERCURRENT_HIGH_LEVEL = 8'hF0;
  localparam logic [7:0] OVERCURRENT_LOW_LEVEL_MAX = 8'hC0;
  localparam logic [7:0] OC_LOW_LEVEL1 = 8'hA0;
  localparam logic [7:0] OC_LOW_LEVEL2 = 8'h80;
  localparam logic [7:0] OC_LOW_LEVEL3 = 8'h60;
  // Watchdog timeouts.
  localparam int WDTO0_MS = 620;
  localparam int WDTO1_MS = 310;
  localparam int WDTO2_MS = 2500;
  localparam int WDTO3_MS = 1250;
  // Fail-safe input settings.
  localparam logic [1:0] FSI_GROUND = 2'h0;
  localparam logic [1:0] FSI_ALL_OFF = 2'h1;
  localparam logic [1:0] FSI_A_ON = 2'h2;
  localparam logic [1:0] FSI_ALL_ON = 2'h3;
  typedef enum {MODE_SLEEP, MODE_NORMAL, MODE_FAILSAFE} sscp_mode_t;
  typedef enum {OC_IDLE, OC_HIGH, OC_LOW} sscp_oc_t;
endpackage

// ---- hw/sscp_sync.sv ----
// Two-flop level synchroniser for pin inputs.
`timescale 1ns/10ps
module sscp_sync
  import sscp_pkg::*;
#(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
)(
  input wire logic core_clk, // Core clock.
  input wire logic rst, // Asynchronous reset, active high.
  input wire logic [W-1:0] d, // Asynchronous levels.
  output logic [W-1:0] q // Synchronised levels.
);
  logic [W-1:0] meta;

  // The first stage feeds only the second stage.
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      meta <= RST_VAL;
      q <= RST_VAL;
    end
    else
    begin
      meta <= d;
      q <= meta;
    end
  end
endmodule

// ---- hw/sscp_shift.sv ----
// Link-side shift register clocked by the host's shift clock.
`timescale 1ns/10ps
module sscp_shift
  import sscp_pkg::*;
(
  input wire logic shift_clk, // Shift clock from the host.
  input wire logic rst, // Asynchronous reset, active high.
  input wire logic cs_n, // Chip select, active low.
  input wire logic serial_in, // Command bit from the host.
  input wire logic [7:0] status, // Quasi-static status word.
  output logic serial_out, // Status bit toward the host.
  output logic [7:0] rx_word, // Last received bits, newest at bit 0.
  output logic [3:0] rx_count // Bits clocked this frame, saturating.
);
  logic armed;
  logic [7:0] tx;

  // Armed while deselected; the first edge of a frame restarts the count.
  always_ff @(posedge shift_clk or posedge cs_n or posedge rst)
  begin
    if (cs_n || rst)
      armed <= 1'b1;
    else
      armed <= 1'b0;
  end

  // Traffic with chip select high is ignored.
  always_ff @(posedge shift_clk or posedge rst)
  begin
    if (rst)
    begin
      rx_word <= 8'h00;
      rx_count <= 4'h0;
      tx <= 8'h00;
    end
    else if (!cs_n)
    begin
      rx_word <= {rx_word[6:0], serial_in};
      tx <= armed ? {status[6:0], 1'b0} : {tx[6:0], 1'b0};
      if (armed)
        rx_count <= 4'h1;
      else if (rx_count != FRAME_CNT_SAT)
        rx_count <= rx_count + 4'h1;
    end
  end

  // Before the first edge the status MSB is already presented.
  assign serial_out = armed ? status[7] : tx[7];

  a_rx_capture: assert property (
    @(posedge shift_clk) disable iff (rst)
    !cs_n |=> rx_word[0] == $past(serial_in))
    else $error("Command bit not captured on rising edge.");
  // The edge after a frame's last one belongs to a new frame, which
  // re-arms and shows the fresh status MSB instead.
  a_tx_advance: assert property (
    @(posedge shift_clk) disable iff (rst)
    !cs_n && !armed |=> armed || serial_out == $past(tx[6]))
    else $error("Status bit did not advance on rising edge.");
endmodule

// ---- hw/sscp_top.sv ----
// Serial control, watchdog, fail-safe and overcurrent staging core.
// Operation
// - Chip select high means all serial traffic is ignored.
// - Shift clock moves command bits in and status bits out.
// - Reset pin low clears configuration and faults, enters sleep unless wake holds fail-safe.
// - Reset pin rising edge starts the watchdog.
// - Wake input high enables the watchdog.
// - Direct inputs drive outputs; their use is set by command.
// - Any detected fault pulls the open-drain fault pin low.
// - Specific fault causes are reported on serial data out.
// - Watchdog timeout drives outputs per fail-safe input setting.
// - Grounded fail-safe input disables watchdog and fail-safe.
// - Command field selects which output feeds current sense.
// - Command can put current sense output in high impedance.
// - During high blanking window only the high level trips.
// - During low blanking times a capped programmable level applies.
// - Commands are 8 bits, MSB first, captured on rising edges.
// - Serial out is high impedance whenever chip select is high.
// - Serial out changes on rising edges for falling-edge sampling.
`timescale 1ns/10ps
module sscp_top
  import sscp_pkg::*;
#(
  parameter int OCL0_CYC = OCL0_US * CLK_MHZ,
  parameter int OCL1_CYC = OCL1_US * CLK_MHZ,
  parameter int OCL2_CYC = OCL2_US * CLK_MHZ,
  parameter int OCL3_CYC = OCL3_US * CLK_MHZ,
  parameter int WDTO0_CYC = WDTO0_MS * CYC_PER_MS,
  parameter int WDTO1_CYC = WDTO1_MS * CYC_PER_MS,
  parameter int WDTO2_CYC = WDTO2_MS * CYC_PER_MS,
  parameter int WDTO3_CYC = WDTO3_MS * CYC_PER_MS
)(
  input wire logic core_clk, // Core clock, 200 MHz.
  input wire logic rst, // Asynchronous reset, active high.
  input wire logic shift_clk, // Serial shift clock from the host.
  input wire logic cs_n, // Chip select pin, active low.
  input wire logic serial_in, // Serial command data in.
  output logic serial_out, // Serial status data out.
  output logic serial_out_oe_n, // Low while serial out is driven.
  input wire logic device_reset_n, // Reset pin, active low.
  input wire logic wake, // Wake pin, high enables the watchdog.
  input wire logic [1:0] direct_input, // Direct inputs for A and B.
  input wire logic [1:0] fail_safe_input, // Fail-safe input setting.
  input wire logic [1:0] fault_flags, // Analog fault detectors.
  input wire logic [7:0] load_current_a, // Digitised current of A.
  input wire logic [7:0] load_current_b, // Digitised current of B.
  output logic high_side_output_a, // Gate command for output A.
  output logic high_side_output_b, // Gate command for output B.
  output logic fault_status_output, // Fault pin level when driven.
  output logic fault_status_oe_n, // Low while the fault pin pulls low.
  output logic [7:0] current_sense_output, // Selected output current.
  output logic current_sense_oe_n, // Low while sense output is driven.
  output logic sleep_state, // High while in sleep.
  output logic watchdog_timeout // High while in fail-safe.
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);

  logic cs_s, rstp_s, wake_s, cs_prev, rstp_prev;
  logic [1:0] din_s, fsi_s, flt_s;
  logic [7:0] rx_word, status_q;
  logic [3:0] rx_count;
  logic [3:0] out_ctrl, oc_cfg;
  logic [1:0] sense_cfg, wd_cfg, hs_q, req, fs_on, oc_flt, oc_trip;
  logic frame_done, frame_ok, wd_run, wd_en, wd_last, kick, timeout;
  logic [31:0] wd_cnt, wd_limit, ocl_limit;
  logic [7:0] low_thr, low_sel;
  logic [7:0] cur [2];
  logic [2:0] cmd_sel;
  logic [3:0] cmd_data;
  sscp_mode_t mode, next_mode;

  // Pins cross into the core clock; reset idles them, so no false edge.
  sscp_sync #(.W(9), .RST_VAL(9'h100)) u_sync (
    .core_clk(core_clk),
    .rst(rst),
    .d({cs_n, device_reset_n, wake, direct_input, fail_safe_input,
        fault_flags}),
    .q({cs_s, rstp_s, wake_s, din_s, fsi_s, flt_s})
  );

  // The shifter runs on the host's clock; its words are read only
  // after chip select rises, when the host keeps the clock idle.
  sscp_shift u_shift (
    .shift_clk(shift_clk),
    .rst(rst),
    .cs_n(cs_n),
    .serial_in(serial_in),
    .status(status_q),
    .serial_out(serial_out),
    .rx_word(rx_word),
    .rx_count(rx_count)
  );

  // Serial out floats whenever the device is deselected.
  assign serial_out_oe_n = cs_n;

  // Edge history of the synchronised chip select and reset pin.
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      cs_prev <= 1'b1;
      rstp_prev <= 1'b0;
    end
    else
    begin
      cs_prev <= cs_s;
      rstp_prev <= rstp_s;
    end
  end

  // A frame counts only when exactly eight bits were clocked.
  assign frame_done = cs_s && !cs_prev;
  assign frame_ok = frame_done && rx_count == FRAME_BITS_CNT &&
    rstp_s;
  assign cmd_sel = rx_word[CMD_SEL_MSB:CMD_SEL_LSB];
  assign cmd_data = rx_word[CMD_DATA_MSB:0];
  assign kick = frame_ok && rx_word[CMD_WD_BIT] != wd_last;

  // Configuration; overcurrent settings fall back to defaults on entry
  // to fail-safe so the protection runs with known thresholds.
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      out_ctrl <= OUT_CTRL_RST;
      oc_cfg <= OC_CFG_RST;
      sense_cfg <= SENSE_RST;
      wd_cfg <= WD_CFG_RST;
    end
    else if (!rstp_s)
    begin
      out_ctrl <= OUT_CTRL_RST;
      oc_cfg <= OC_CFG_RST;
      sense_cfg <= SENSE_RST;
      wd_cfg <= WD_CFG_RST;
    end
    else
    begin
      if (frame_ok && cmd_sel == REG_OUT_CTRL)
        out_ctrl <= cmd_data;
      if (mode == MODE_NORMAL && timeout)
        oc_cfg <= OC_CFG_RST;
      else if (frame_ok && cmd_sel == REG_OC_CFG)
        oc_cfg <= cmd_data;
      if (frame_ok && cmd_sel == REG_SENSE)
        sense_cfg <= cmd_data[1:0];
      if (frame_ok && cmd_sel == REG_WD_CFG)
        wd_cfg <= cmd_data[1:0];
    end
  end

  // Watchdog arming and counting; a grounded fail-safe input stops it.
  assign wd_en = wd_run && fsi_s != FSI_GROUND;
  assign timeout = wd_en && wd_cnt >= wd_limit;

  always_comb
  begin
    case (wd_cfg)
      2'h0: wd_limit = 32'(WDTO0_CYC);
      2'h1: wd_limit = 32'(WDTO1_CYC);
      2'h2: wd_limit = 32'(WDTO2_CYC);
      default: wd_limit = 32'(WDTO3_CYC);
    endcase
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      wd_run <= 1'b0;
      wd_cnt <= 32'h00000000;
      wd_last <= 1'b0;
    end
    else
    begin
      if (fsi_s == FSI_GROUND || (!rstp_s && !wake_s))
        wd_run <= 1'b0;
      else if ((rstp_s && !rstp_prev) || wake_s)
        wd_run <= 1'b1;
      if (frame_ok)
        wd_last <= rx_word[CMD_WD_BIT];
      if (!wd_en || kick || mode != MODE_NORMAL)
        wd_cnt <= 32'h00000000;
      else if (!timeout)
        wd_cnt <= wd_cnt + 32'h00000001;
    end
  end

  // Operating mode sequencing.
  always_comb
  begin
    next_mode = mode;
    case (mode)
      MODE_SLEEP:
        if (rstp_s)
          next_mode = MODE_NORMAL;
      MODE_NORMAL:
        if (!rstp_s)
          next_mode = MODE_SLEEP;
        else if (timeout)
          next_mode = MODE_FAILSAFE;
      MODE_FAILSAFE:
        if ((!rstp_s && !wake_s) || fsi_s == FSI_GROUND)
          next_mode = MODE_SLEEP;
      default:
        next_mode = MODE_SLEEP;
    endcase
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      mode <= MODE_SLEEP;
    else
      mode <= next_mode;
  end

  // Output requests: direct input or serial bit, per channel.
  assign fs_on[0] = fsi_s == FSI_A_ON || fsi_s == FSI_ALL_ON;
  assign fs_on[1] = fsi_s == FSI_ALL_ON;
  assign cur[0] = load_current_a;
  assign cur[1] = load_current_b;

  // Low threshold table, never above the capped maximum.
  always_comb
  begin
    case (oc_cfg[1:0])
      2'h0: low_sel = OVERCURRENT_LOW_LEVEL_MAX;
      2'h1: low_sel = OC_LOW_LEVEL1;
      2'h2: low_sel = OC_LOW_LEVEL2;
      default: low_sel = OC_LOW_LEVEL3;
    endcase
    low_thr = (low_sel > OVERCURRENT_LOW_LEVEL_MAX) ?
      OVERCURRENT_LOW_LEVEL_MAX : low_sel;
    case (oc_cfg[3:2])
      2'h0: ocl_limit = 32'(OCL0_CYC);
      2'h1: ocl_limit = 32'(OCL1_CYC);
      2'h2: ocl_limit = 32'(OCL2_CYC);
      default: ocl_limit = 32'(OCL3_CYC);
    endcase
  end

  // Per-channel gating and overcurrent staging.
  for (genvar i = 0; i < 2; i++)
  begin : g_chan
    sscp_oc_t oc_st;
    logic [31:0] cnt;

    assign req[i] = out_ctrl[OUT_DIRECT_EN_LSB + i] ?
      din_s[i] : out_ctrl[OUT_SPI_ON_LSB + i];

    // High window trips only on the high level; the low window needs
    // the low level to persist for the whole selected blanking time.
    always_comb
    begin
      oc_trip[i] = 1'b0;
      case (oc_st)
        OC_HIGH: oc_trip[i] = cur[i] > OVERCURRENT_HIGH_LEVEL;
        OC_LOW: oc_trip[i] = cur[i] > OVERCURRENT_HIGH_LEVEL ||
          (cur[i] > low_thr && cnt >= ocl_limit - 32'h1);
        default: oc_trip[i] = 1'b0;
      endcase
    end

    always_ff @(posedge core_clk or posedge rst)
    begin
      if (rst)
      begin
        oc_st <= OC_IDLE;
        cnt <= 32'h00000000;
      end
      else if (!hs_q[i] || oc_trip[i])
      begin
        oc_st <= OC_IDLE;
        cnt <= 32'h00000000;
      end
      else
        case (oc_st)
          OC_IDLE:
          begin
            oc_st <= OC_HIGH;
            cnt <= 32'h00000000;
          end
          OC_HIGH:
            if (cnt == 32'(OCH_CYC - 1))
            begin
              oc_st <= OC_LOW;
              cnt <= 32'h00000000;
            end
            else
              cnt <= cnt + 32'h00000001;
          OC_LOW:
            cnt <= (cur[i] > low_thr) ? cnt + 32'h00000001 : 32'h00000000;
          default:
            oc_st <= OC_IDLE;
        endcase
    end

    // A trip in the same cycle as a software clear still latches.
    always_ff @(posedge core_clk or posedge rst)
    begin
      if (rst)
        oc_flt[i] <= 1'b0;
      else if (!rstp_s)
        oc_flt[i] <= 1'b0;
      else if (oc_trip[i])
        oc_flt[i] <= 1'b1;
      else if (frame_ok && cmd_sel == REG_OUT_CTRL)
        oc_flt[i] <= 1'b0;
    end

    a_och_trip: assert property (
      oc_st == OC_HIGH && hs_q[i] && rstp_s &&
      cur[i] > OVERCURRENT_HIGH_LEVEL |=> oc_flt[i])
      else $error("High-level overcurrent did not trip.");
    a_och_tolerate: assert property (
      oc_st == OC_HIGH && cur[i] <= OVERCURRENT_HIGH_LEVEL &&
      !oc_flt[i] |=> !oc_flt[i])
      else $error("Tripped below the high level in the high window.");
  end

  // Output drive, fault pin, sense and status snapshot.
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      hs_q <= 2'b00;
      fault_status_oe_n <= 1'b1;
      current_sense_output <= 8'h00;
      current_sense_oe_n <= 1'b1;
      status_q <= STATUS_RST;
    end
    else
    begin
      for (int k = 0; k < 2; k++)
        hs_q[k] <= (mode == MODE_FAILSAFE) ? fs_on[k] :
          (mode == MODE_NORMAL && rstp_s && req[k] && !oc_flt[k]);
      fault_status_oe_n <= !(|oc_flt || |flt_s);
      current_sense_output <= sense_cfg[SENSE_CHAN_BIT] ?
        load_current_b : load_current_a;
      current_sense_oe_n <= !sense_cfg[SENSE_EN_BIT];
      // Frozen while selected so the link sees a steady word.
      if (cs_s)
        status_q <= {oc_flt[0], oc_flt[1], flt_s, wd_en,
          mode == MODE_FAILSAFE, hs_q[1], hs_q[0]};
    end
  end

  assign high_side_output_a = hs_q[0];
  assign high_side_output_b = hs_q[1];
  assign fault_status_output = 1'b0;
  assign sleep_state = mode == MODE_SLEEP;
  assign watchdog_timeout = mode == MODE_FAILSAFE;

  sequence s_bad_frame;
    frame_done && rx_count != FRAME_BITS_CNT && rstp_s;
  endsequence
  sequence s_gnd_held;
    fsi_s == FSI_GROUND ##1 fsi_s == FSI_GROUND;
  endsequence

  a_frame_len: assert property (s_bad_frame |=> $stable(out_ctrl))
    else $error("Frame of wrong length changed configuration.");
  a_rst_clear: assert property (
    !rstp_s |=> out_ctrl == OUT_CTRL_RST && oc_flt == 2'b00 &&
    mode != MODE_NORMAL)
    else $error("Reset pin low did not clear state.");
  a_wd_start: assert property (
    rstp_s && !rstp_prev && fsi_s != FSI_GROUND |=> wd_run)
    else $error("Reset pin rise did not start watchdog.");
  a_wake_en: assert property (
    wake_s && fsi_s != FSI_GROUND |=> wd_run)
    else $error("Wake high did not enable watchdog.");
  a_fsi_gnd: assert property (
    s_gnd_held |-> mode != MODE_FAILSAFE && !wd_en)
    else $error("Grounded fail-safe input left watchdog active.");
  a_direct_follow: assert property (
    mode == MODE_NORMAL && rstp_s && out_ctrl[OUT_DIRECT_EN_LSB] &&
    !oc_flt[0] |=> high_side_output_a == $past(din_s[0]))
    else $error("Output A did not follow its direct input.");
  a_failsafe_out: assert property (
    mode == MODE_FAILSAFE && fsi_s == FSI_A_ON |=>
    high_side_output_a && !high_side_output_b)
    else $error("Fail-safe outputs do not match the setting.");
  a_fault_pin: assert property (|oc_flt |=> !fault_status_oe_n)
    else $error("Fault pin not pulled low on a fault.");
  a_sense_route: assert property (
    sense_cfg == 2'b11 |=>
    current_sense_output == $past(load_current_b) && !current_sense_oe_n)
    else $error("Current sense not routed from output B.");
  a_sense_float: assert property (
    !sense_cfg[SENSE_EN_BIT] |=> current_sense_oe_n)
    else $error("Current sense driven while disabled.");
endmodule

// ---- tb/sscp_host_model.sv ----
// Host serial master model that frames commands for the core.
`timescale 1ns/10ps
module sscp_host_model (
  output logic shift_clk, // Shift clock, parked low.
  output logic cs_n, // Chip select, active low.
  output logic serial_in, // Command bit toward the device.
  input wire logic serial_out, // Status bit from the device.
  input wire logic serial_out_oe_n // Low while status is driven.
);
  localparam int HALF = 40;
  // Idle levels: deselected, clock still, data at its pull-down level.
  initial
  begin
    shift_clk = 1'b0;
    cs_n = 1'b1;
    serial_in = 1'b0;
  end
  // One frame of nbits bits, with chip select low only when sel is set.
  // Status is taken just before each rising edge, a full period after
  // the device moved it, since an undriven line must not pass as data.
  task automatic xfer(input logic [7:0] cmd, input int nbits,
                      input logic sel, output logic [7:0] rx);
    int i;
    rx = 8'h00;
    #7;
    cs_n = ~sel;
    for (i = 7; i > 7 - nbits; i--)
    begin
      serial_in = cmd[i];
      #HALF;
      rx[i] = serial_out_oe_n ? 1'bx : serial_out;
      shift_clk = 1'b1;
      #HALF;
      shift_clk = 1'b0;
    end
    #HALF;
    cs_n = 1'b1;
    serial_in = 1'b0;
    #HALF;
  endtask
endmodule

// ---- tb/sscp_top_tb_top.sv ----
// Self-checking bench for the switch serial control core.
`timescale 1ns/10ps
module sscp_top_tb_top;
  import sscp_pkg::*;
  logic core_clk, rst, shift_clk, cs_n, serial_in, serial_out;
  logic serial_out_oe_n, device_reset_n, wake, hs_a, hs_b;
  logic fault_status_oe_n, current_sense_oe_n, sleep_state;
  logic watchdog_timeout, fs_out;
  logic [1:0] direct_input, fail_safe_input, fault_flags;
  logic [7:0] load_current_a, load_current_b, current_sense_output;
  logic [7:0] lfsr, rx;
  logic wdb;
  int errors, comparisons, i, j;
  // Short counts keep blanking and watchdog runs brief; only the
  // settings that the scenarios select are shortened.
  sscp_top #(.OCL0_CYC(200), .OCL3_CYC(20), .WDTO0_CYC(600)) dut_u (
    .core_clk(core_clk), .rst(rst), .shift_clk(shift_clk),
    .cs_n(cs_n), .serial_in(serial_in), .serial_out(serial_out),
    .serial_out_oe_n(serial_out_oe_n),
    .device_reset_n(device_reset_n), .wake(wake),
    .direct_input(direct_input), .fail_safe_input(fail_safe_input),
    .fault_flags(fault_flags), .load_current_a(load_current_a),
    .load_current_b(load_current_b), .high_side_output_a(hs_a),
    .high_side_output_b(hs_b), .fault_status_output(fs_out),
    .fault_status_oe_n(fault_status_oe_n),
    .current_sense_output(current_sense_output),
    .current_sense_oe_n(current_sense_oe_n),
    .sleep_state(sleep_state), .watchdog_timeout(watchdog_timeout));
  sscp_host_model host_u (.shift_clk(shift_clk), .cs_n(cs_n),
    .serial_in(serial_in), .serial_out(serial_out),
    .serial_out_oe_n(serial_out_oe_n));
  // Core clock at 200 MHz.
  initial
  begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end
  function automatic logic [7:0] lfsr_next(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  // Gate levels: a direct-enable bit hands the output to its pin.
  function automatic logic [1:0] exp_gate(input logic [3:0] d,
                                          input logic [1:0] din);
    return {d[3] ? din[1] : d[1], d[2] ? din[0] : d[0]};
  endfunction
  function automatic logic seen(input int w);
    return w == 0 ? watchdog_timeout : ~hs_a;
  endfunction
  task automatic tally_and_finish();
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp,
                     input string what);
    comparisons++;
    if (got !== exp)
    begin
      errors++;
      $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  // Scenario inputs change 1 ns after a rising edge; host pins keep their own timing.
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  // Sends one frame, then leaves time for the crossing and the update.
  task automatic cmd(input logic [7:0] c, input int n);
    host_u.xfer(c, n, 1'b1, rx);
    cyc(8);
  endtask
  // Bounded wait; running out counts a mismatch and ends the run.
  task automatic wait_for(input int w, input int lim);
    int n;
    for (n = 0; n < lim && seen(w) !== 1'b1; n++)
      cyc(1);
    comparisons++;
    if (seen(w) !== 1'b1)
    begin
      errors++;
      $display("ERROR %0t wait %0d ran out", $time, w);
      tally_and_finish();
    end
  endtask
  // Main sequence.
  initial
  begin
    rst = 1'b1;
    device_reset_n = 1'b0;
    wake = 1'b0;
    direct_input = 2'h0;
    fail_safe_input = FSI_GROUND;
    fault_flags = 2'h0;
    load_current_a = 8'h00;
    load_current_b = 8'h00;
    lfsr = 8'h38;
    wdb = 1'b0;
    errors = 0;
    comparisons = 0;
    repeat (20) @(posedge core_clk);
    #1;
    rst = 1'b0;
    cyc(5);
    cmd(8'h03, 8);
    chk({sleep_state, fault_status_oe_n, current_sense_oe_n,
      serial_out_oe_n, hs_a, hs_b, watchdog_timeout, fs_out}, 8'hF0,
      "reset");
    device_reset_n = 1'b1;
    cyc(10);
    chk({7'h00, sleep_state}, 8'h00, "awake");
    $display("test reset done");
    // Random gate commands, each followed by ignored frames.
    for (i = 0; i < 8; i++)
    begin
      lfsr = lfsr_next(lfsr);
      direct_input = lfsr[5:4];
      fault_flags = lfsr[7:6];
      cmd({4'h0, lfsr[3:0]}, 8);
      host_u.xfer(~lfsr, 8, 1'b0, rx);
      cmd(~lfsr, 7);
      chk({6'h00, hs_b, hs_a}, {6'h00, exp_gate(lfsr[3:0], lfsr[5:4])},
        "gates");
      cmd(8'h70, 8);
      chk(rx, {2'h0, lfsr[7:6], 2'h0, exp_gate(lfsr[3:0], lfsr[5:4])},
        "status");
      chk({7'h00, fault_status_oe_n}, {7'h00, ~|lfsr[7:6]},
        "fault pin");
    end
    fault_flags = 2'h0;
    direct_input = 2'h0;
    // Every sense selection, with and without the driver enabled.
    for (j = 0; j < 4; j++)
    begin
      lfsr = lfsr_next(lfsr);
      load_current_a = lfsr;
      load_current_b = ~lfsr;
      cmd({6'h08, j[1:0]}, 8);
      chk({7'h00, current_sense_oe_n}, {7'h00, ~j[1]}, "sense en");
      if (j[1])
        chk(current_sense_output, j[0] ? ~lfsr : lfsr, "sense");
    end
    $display("test serial done");
    load_current_a = 8'hF1;
    cmd(8'h01, 8);
    wait_for(1, 20);
    cmd(8'h70, 8);
    chk({7'h00, rx[7]}, 8'h01, "oc status");
    chk({7'h00, fault_status_oe_n}, 8'h00, "oc pin");
    load_current_a = 8'hF0;
    cmd(8'h01, 8);
    cyc(200);
    chk({7'h00, hs_a}, 8'h01, "high level held");
    cmd(8'h1F, 8);
    load_current_a = 8'h70;
    cmd(8'h00, 8);
    cmd(8'h01, 8);
    cyc(1900);
    chk({7'h00, hs_a}, 8'h01, "high window");
    wait_for(1, 400);
    cmd(8'h00, 8);
    load_current_a = 8'h00;
    $display("test overcurrent done");
    // Each non-grounded fail-safe setting, started by the reset pin rising.
    for (i = 1; i < 4; i++)
    begin
      fail_safe_input = i[1:0];
      device_reset_n = 1'b0;
      cyc(10);
      device_reset_n = 1'b1;
      cyc(10);
      for (j = 0; j < 5; j++)
      begin
        wdb = ~wdb;
        cmd({wdb, 7'h70}, 8);
      end
      chk({7'h00, watchdog_timeout}, 8'h00, "kept alive");
      wait_for(0, 1500);
      // The gates follow the mode register one edge later.
      cyc(2);
      chk({6'h00, hs_b, hs_a}, {6'h00, i == 3, i >= 2}, "fs out");
      device_reset_n = 1'b0;
      cyc(10);
      chk({7'h00, watchdog_timeout}, 8'h00, "fs exit");
    end
    // The reset pin rises while grounded, so only wake can start it.
    fail_safe_input = FSI_GROUND;
    cyc(10);
    device_reset_n = 1'b1;
    cyc(10);
    fail_safe_input = FSI_ALL_ON;
    cyc(700);
    chk({7'h00, watchdog_timeout}, 8'h00, "no wake");
    wake = 1'b1;
    wait_for(0, 1500);
    wake = 1'b0;
    device_reset_n = 1'b0;
    fail_safe_input = FSI_GROUND;
    cyc(10);
    wake = 1'b1;
    device_reset_n = 1'b1;
    cyc(1200);
    chk({7'h00, watchdog_timeout}, 8'h00, "grounded");
    $display("test watchdog done");
    tally_and_finish();
  end
endmodule
